//--- src/info_pkg.sv
// Constants and types for the information query block.
// Assumes one clock domain and a 32-bit register bus.
`default_nettype none
package info_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_RESP = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CFG = 8'h0C;
  // Command word fields
  localparam int CMD_MODE_LSB = 0;
  localparam int CMD_PARAM_LSB = 8;
  localparam logic [2:0] CMD_STRB_ALL = 3'h7;
  // Status bits
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  // Config fields and reset value
  localparam int CFG_FUNC_LSB = 0;
  localparam int CFG_TWO_WIRE = 2;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  // Sub-function codes and answers
  localparam logic [7:0] MODE_STATE = 8'h02;
  localparam logic [7:0] MODE_PIN = 8'h03;
  localparam logic [7:0] ERR_PARSE = 8'h03;
  localparam logic [7:0] ERR_EXEC = 8'h0F;
  // Second parameter bits
  localparam int PRM_DIR = 1;
  localparam int PRM_LVL = 0;
  // Bus answers
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PIN_OFF = 2'h0,
    PIN_AUTH = 2'h1,
    PIN_IN = 2'h2,
    PIN_OUT = 2'h3
  } pin_func_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_BUSY = 2'b10
  } exec_state_t;

  typedef struct packed {
    logic scratch_no_mac_flag;
    logic scratch_generated_key_flag;
    logic scratch_generated_digest_flag;
    logic scratch_source_flag;
    logic [3:0] scratch_slot_id;
    logic scratch_valid_flag;
    logic [3:0] authorized_slot_number;
    logic authorization_done_flag;
    logic volatile_seed_refreshed;
    logic stored_seed_refreshed;
  } dev_state_t;
endpackage
`default_nettype wire

//--- src/info_if.sv
// Request and answer path between the bus front end and the executor.
// Assumes both ends share clk_sys.
`timescale 1ns/100ps
`default_nettype none
interface info_if;
  logic req;
  logic [7:0] mode;
  logic [15:0] second_parameter;
  logic done;
  logic err;
  logic [31:0] data;
  modport host(output req, mode, second_parameter, input done, err, data);
  modport exec(input req, mode, second_parameter, output done, err, data);
endinterface
`default_nettype wire

//--- src/info_exec.sv
// Executor for the state report and pin access sub-functions.
// Assumes a one-cycle req pulse; answers with done one cycle later.
`timescale 1ns/100ps
`default_nettype none
module info_exec (
  input wire logic clk_sys,
  input wire logic rst,
  info_if.exec cmd,
  input wire info_pkg::pin_func_t pin_func,
  input wire logic two_wire,
  input wire logic pin_level,
  input wire info_pkg::dev_state_t st,
  output logic pin_drive,
  output logic pin_enable
);
  import info_pkg::*;

  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] data;
    logic drive;
    logic enable;
  } exec_regs_t;

  exec_regs_t q_q, q_d;
  logic [15:0] prm;

  assign prm = cmd.second_parameter;

  always_comb begin
    q_d = q_q;
    q_d.done = cmd.req;
    if (cmd.req) begin
      q_d.err = 1'b0;
      q_d.data = '0;
      case (cmd.mode)
        MODE_STATE: begin
          q_d.data = {16'h0000, // R5
                      st.scratch_valid_flag, // R11
                      st.authorized_slot_number, // R1
                      st.authorization_done_flag, // R2
                      st.volatile_seed_refreshed, // R3
                      st.stored_seed_refreshed, // R4
                      st.scratch_no_mac_flag, // R10
                      st.scratch_generated_key_flag, // R10
                      st.scratch_generated_digest_flag, // R11
                      st.scratch_source_flag, // R11
                      st.scratch_slot_id}; // R11
        end
        MODE_PIN: begin
          if (pin_func == PIN_OFF || two_wire) begin // R6 R13
            q_d.err = 1'b1;
            q_d.data = {24'h00_0000, ERR_EXEC};
          end else if (prm[15:2] != 14'h0000) begin // R7
            q_d.err = 1'b1;
            q_d.data = {24'h00_0000, ERR_PARSE};
          end else if (pin_func == PIN_IN && prm[PRM_DIR]) begin // R14
            q_d.err = 1'b1;
            q_d.data = {24'h00_0000, ERR_EXEC};
          end else begin
            // Level is the pin as seen before any new drive
            q_d.data = {24'h00_0000, 7'h00, pin_level}; // R9
            if (pin_func == PIN_OUT) begin
              q_d.enable = prm[PRM_DIR];
              if (prm[PRM_DIR]) begin // R8
                q_d.drive = prm[PRM_LVL];
              end
            end
          end
        end
        default: begin
          q_d.err = 1'b1;
          q_d.data = {24'h00_0000, ERR_PARSE}; // R12
        end
      endcase
    end
    if (rst) begin
      q_d = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    q_q <= q_d;
  end

  assign cmd.done = q_q.done;
  assign cmd.err = q_q.err;
  assign cmd.data = q_q.data;
  assign pin_drive = q_q.drive;
  assign pin_enable = q_q.enable;

  a_level_ignored: assert property ( // R8
    @(posedge clk_sys) disable iff (rst)
    (cmd.req && cmd.mode == MODE_PIN && !prm[PRM_DIR])
      |=> (pin_drive == $past(pin_drive)))
    else $error("Pin level changed with direction input");

  a_pin_answer: assert property ( // R9
    @(posedge clk_sys) disable iff (rst)
    (cmd.req && cmd.mode == MODE_PIN && (pin_func == PIN_OUT)
      && !two_wire && prm[15:2] == 14'h0000)
      |=> (!cmd.err && cmd.data == {31'h0000_0000, $past(pin_level)}))
    else $error("Pin answer not level plus zero bytes");

  a_bad_mode: assert property ( // R12
    @(posedge clk_sys) disable iff (rst)
    (cmd.req && cmd.mode != MODE_STATE && cmd.mode != MODE_PIN)
      |=> (cmd.done && cmd.err && cmd.data[7:0] == ERR_PARSE))
    else $error("Unsupported mode not answered with parse error");

  a_pin_unavailable: assert property ( // R13
    @(posedge clk_sys) disable iff (rst)
    (cmd.req && cmd.mode == MODE_PIN && (two_wire || pin_func == PIN_OFF))
      |=> (cmd.err && $stable(pin_enable) && $stable(pin_drive)))
    else $error("Pin access allowed while unavailable");

  a_input_only: assert property ( // R14
    @(posedge clk_sys) disable iff (rst)
    (cmd.req && cmd.mode == MODE_PIN && pin_func == PIN_IN && !two_wire
      && prm[PRM_DIR])
      |=> (cmd.err && !pin_enable == !$past(pin_enable)))
    else $error("Output request accepted in input-only setup");
endmodule // info_exec
`default_nettype wire

//--- src/info_query.sv
// Bus front end of the information query block with its register file.
// Assumes an AXI4-Lite master on clk_sys and device state inputs.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Operation
// [R1] State report byte 2 bits 6..3 carry the last authorized slot.
// [R2] State report byte 2 bit 2 shows a completed authorization.
// [R3] State report byte 2 bit 1 shows volatile seed refreshed.
// [R4] State report byte 2 bit 0 shows stored seed refreshed.
// [R5] State report bytes 3 and 4 are always zero.
// [R6] Pin access, mode 3, works only in single-wire setups.
// [R7] Host sends parameter bits 15..2 zero, bit 1 selects direction.
// [R8] Parameter bit 0 is the drive level, ignored when bit 1 is zero.
// [R9] Pin answer: pin level in byte 1, then three zero bytes.
// [R10] Mode 2 selects state report; byte 1 bits 7, 6 are flags.
// [R11] Byte 1 bits 5..0 and byte 2 bit 7 hold scratch fields.
// [R12] Unsupported mode values give a parse error answer.
// [R13] Pin disabled or two-wire setup: pin access gives an error.
// [R14] Input-only setup: output request gives an error.
module info_query #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scratch_no_mac_flag,
  input wire logic scratch_generated_key_flag,
  input wire logic scratch_generated_digest_flag,
  input wire logic scratch_source_flag,
  input wire logic [3:0] scratch_slot_id,
  input wire logic scratch_valid_flag,
  input wire logic [3:0] authorized_slot_number,
  input wire logic authorization_done_flag,
  input wire logic volatile_seed_refreshed,
  input wire logic stored_seed_refreshed,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe
);
  import info_pkg::*;

  if (ADDR_W < 8) begin : g_bad_width
    $error("ADDR_W must be at least 8");
  end

  typedef struct packed {
    exec_state_t state;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic req;
    logic [7:0] mode;
    logic [15:0] second_parameter;
    logic [31:0] resp;
    logic done;
    logic err;
    pin_func_t cfg_func;
    logic cfg_two_wire;
    logic pin_out;
    logic pin_oe;
  } main_regs_t;

  main_regs_t s_q, s_d;
  dev_state_t dev_st;
  logic ex_drive;
  logic ex_enable;

  info_if ifc ();

  // Word match; bits above the map must be zero
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    return (a[7:2] == off[7:2]) && ((a >> 8) == '0);
  endfunction

  assign dev_st = '{
    scratch_no_mac_flag: scratch_no_mac_flag,
    scratch_generated_key_flag: scratch_generated_key_flag,
    scratch_generated_digest_flag: scratch_generated_digest_flag,
    scratch_source_flag: scratch_source_flag,
    scratch_slot_id: scratch_slot_id,
    scratch_valid_flag: scratch_valid_flag,
    authorized_slot_number: authorized_slot_number,
    authorization_done_flag: authorization_done_flag,
    volatile_seed_refreshed: volatile_seed_refreshed,
    stored_seed_refreshed: stored_seed_refreshed
  };

  assign ifc.req = s_q.req;
  assign ifc.mode = s_q.mode;
  assign ifc.second_parameter = s_q.second_parameter;

  info_exec u_exec (
    .clk_sys(clk_sys),
    .rst(rst),
    .cmd(ifc.exec),
    .pin_func(s_q.cfg_func),
    .two_wire(s_q.cfg_two_wire),
    .pin_level(pin_in),
    .st(dev_st),
    .pin_drive(ex_drive),
    .pin_enable(ex_enable)
  );

  always_comb begin
    s_d = s_q;
    s_d.req = 1'b0;
    s_d.pin_out = ex_drive;
    s_d.pin_oe = ex_enable;
    // Address and data are taken in either order
    if (s_q.awready && s_axi_awvalid) begin
      s_d.awready = 1'b0;
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.wready = 1'b0;
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = AXI_OKAY;
      if (hit(s_q.awaddr, OFF_CMD)) begin
        // A command needs all three bytes and an idle executor
        if (s_q.state != S_IDLE || s_q.wstrb[2:0] != CMD_STRB_ALL) begin
          s_d.bresp = AXI_SLVERR;
        end else begin
          s_d.req = 1'b1;
          s_d.mode = s_q.wdata[CMD_MODE_LSB +: 8];
          s_d.second_parameter = s_q.wdata[CMD_PARAM_LSB +: 16];
          s_d.state = S_BUSY;
          s_d.done = 1'b0;
          s_d.err = 1'b0;
        end
      end else if (hit(s_q.awaddr, OFF_CFG)) begin
        if (s_q.wstrb[0]) begin
          s_d.cfg_func = pin_func_t'(s_q.wdata[CFG_FUNC_LSB +: 2]);
          s_d.cfg_two_wire = s_q.wdata[CFG_TWO_WIRE];
        end
      end else if (!hit(s_q.awaddr, OFF_RESP)
                   && !hit(s_q.awaddr, OFF_STATUS)) begin
        s_d.bresp = AXI_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end
    // Answer capture from the executor
    if (s_q.state == S_BUSY && ifc.done) begin
      s_d.resp = ifc.data;
      s_d.err = ifc.err;
      s_d.done = 1'b1;
      s_d.state = S_IDLE;
    end
    if (s_q.arready && s_axi_arvalid) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = AXI_OKAY;
      if (hit(s_axi_araddr, OFF_CMD)) begin
        s_d.rdata = {8'h00, s_q.second_parameter, s_q.mode};
      end else if (hit(s_axi_araddr, OFF_RESP)) begin
        s_d.rdata = s_q.resp;
      end else if (hit(s_axi_araddr, OFF_STATUS)) begin
        s_d.rdata = '0;
        s_d.rdata[ST_BUSY] = (s_q.state == S_BUSY);
        s_d.rdata[ST_DONE] = s_q.done;
        s_d.rdata[ST_ERR] = s_q.err;
      end else if (hit(s_axi_araddr, OFF_CFG)) begin
        s_d.rdata = '0;
        s_d.rdata[CFG_FUNC_LSB +: 2] = s_q.cfg_func;
        s_d.rdata[CFG_TWO_WIRE] = s_q.cfg_two_wire;
      end else begin
        s_d.rdata = '0;
        s_d.rresp = AXI_SLVERR;
      end
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end
    if (rst) begin
      s_d = '0;
      s_d.state = S_IDLE;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
      s_d.arready = 1'b1;
      s_d.cfg_func = pin_func_t'(CFG_RST[CFG_FUNC_LSB +: 2]);
      s_d.cfg_two_wire = CFG_RST[CFG_TWO_WIRE];
    end
  end

  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign pin_out = s_q.pin_out;
  assign pin_oe = s_q.pin_oe;

  a_slot_number: assert property ( // R1
    @(posedge clk_sys) disable iff (rst)
    (ifc.req && ifc.mode == MODE_STATE)
      |-> ##2 (s_q.resp[14:11] == $past(authorized_slot_number, 2)))
    else $error("Authorized slot not in byte 2 bits 6..3");

  a_auth_done: assert property ( // R2
    @(posedge clk_sys) disable iff (rst)
    (ifc.req && ifc.mode == MODE_STATE)
      |-> ##2 (s_q.resp[10] == $past(authorization_done_flag, 2)
               && s_q.done && !s_q.err))
    else $error("Authorization flag not in byte 2 bit 2");

  a_seed_flags: assert property ( // R3
    @(posedge clk_sys) disable iff (rst)
    (ifc.req && ifc.mode == MODE_STATE)
      |-> ##2 (s_q.resp[9] == $past(volatile_seed_refreshed, 2)))
    else $error("Volatile seed flag not in byte 2 bit 1");

  a_stored_seed: assert property ( // R4
    @(posedge clk_sys) disable iff (rst)
    (ifc.req && ifc.mode == MODE_STATE)
      |-> ##2 (s_q.resp[8] == $past(stored_seed_refreshed, 2)))
    else $error("Stored seed flag not in byte 2 bit 0");

  a_upper_zero: assert property ( // R5
    @(posedge clk_sys) disable iff (rst)
    (s_q.state == S_BUSY && ifc.done)
      |=> (s_q.resp[31:16] == 16'h0000 && s_q.state == S_IDLE))
    else $error("Upper answer bytes not zero");

  a_first_byte: assert property ( // R10
    @(posedge clk_sys) disable iff (rst)
    (ifc.req && ifc.mode == MODE_STATE)
      |-> ##2 (s_q.resp[7:6] == $past({scratch_no_mac_flag,
                                     scratch_generated_key_flag}, 2)
               && s_q.resp[3:0] == $past(scratch_slot_id, 2)))
    else $error("State report first byte misplaced");
endmodule // info_query
`default_nettype wire

//--- verification/pin_partner.sv
// Outside circuit on the general purpose pin: a weak source and the wire.
// Assumes the block drives the pin only while pin_oe is high.
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic ext_level,
  output logic pin_level
);
  // Block wins while enabled; the outside source yields to it
  assign pin_level = pin_oe ? pin_out : ext_level;
endmodule // pin_partner
`default_nettype wire

//--- verification/info_query_bench.sv
// Self-checking bench for the information query block.
// Assumes an AXI4-Lite slave on clk_sys and the pin partner on the pin.
`timescale 1ns/100ps
`default_nettype none
module info_query_bench;
  import info_pkg::*;
  logic clk_sys, rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [15:0] dev;
  logic pin_in, pin_out, pin_oe, ext_level;
  logic [33:0] q[$];
  logic [7:0] bad[4] = '{8'h00, 8'h01, 8'h04, 8'hFF};
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;

  info_query i_info_query (
    .clk_sys, .rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .scratch_no_mac_flag(dev[7]), .scratch_generated_key_flag(dev[6]),
    .scratch_generated_digest_flag(dev[5]), .scratch_source_flag(dev[4]),
    .scratch_slot_id(dev[3:0]), .scratch_valid_flag(dev[15]),
    .authorized_slot_number(dev[14:11]),
    .authorization_done_flag(dev[10]),
    .volatile_seed_refreshed(dev[9]),
    .stored_seed_refreshed(dev[8]),
    .pin_in, .pin_out, .pin_oe
  );
  pin_partner i_pin_partner (.pin_out, .pin_oe, .ext_level,
                             .pin_level(pin_in));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Results appear one at a time, so one queue serves both channels
  always @(posedge clk_sys) begin
    if (!rst && s_axi_rvalid && s_axi_rready) begin
      check({s_axi_rresp, s_axi_rdata}, q.pop_front());
    end else if (!rst && s_axi_bvalid && s_axi_bready) begin
      check({s_axi_bresp, 32'h0000_0000}, q.pop_front());
    end
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  // Leading edge keeps a new request off the previous release
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF,
                    input logic [1:0] r = AXI_OKAY);
    @(posedge clk_sys);
    q.push_back({r, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = AXI_OKAY);
    @(posedge clk_sys);
    q.push_back({r, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task automatic query(input logic [7:0] m, input logic [15:0] p,
                       input logic e, input logic [31:0] resp);
    wr(OFF_CMD, {8'h00, p, m});
    rd(OFF_STATUS, {29'h0000_0000, e, 2'h2});
    rd(OFF_RESP, resp);
  endtask

  task automatic pins(input logic oe, input logic lvl);
    check({32'h0000_0000, pin_oe, pin_out}, {32'h0000_0000, oe, lvl});
  endtask

  task automatic note(input string s);
    $display("test %s finished", s);
  endtask

  initial begin
    logic [15:0] v;
    rst <= 1'b1;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_awprot <= 3'h0;
    s_axi_arprot <= 3'h0;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    s_axi_wdata <= 32'h0000_0000;
    s_axi_wstrb <= 4'h0;
    dev <= 16'h0000;
    ext_level <= 1'b0;
    void'($urandom(50));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFF_CFG, CFG_RST);
    rd(OFF_STATUS, 32'h0000_0000);
    note("reset values");
    for (int i = 0; i < 20; i++) begin
      v = (i < 16) ? 16'h0001 << i : 16'($urandom);
      dev <= v;
      query(MODE_STATE, 16'h0000, 1'b0, {16'h0000, v});
    end
    note("state report");
    foreach (bad[i]) query(bad[i], 16'h0000, 1'b1, {24'h00_0000, ERR_PARSE});
    note("unsupported modes");
    wr(OFF_CFG, 32'h0000_0000);
    query(MODE_PIN, 16'h0000, 1'b1, {24'h00_0000, ERR_EXEC});
    wr(OFF_CFG, 32'h0000_0007);
    query(MODE_PIN, 16'h0003, 1'b1, {24'h00_0000, ERR_EXEC});
    pins(1'b0, 1'b0);
    wr(OFF_CFG, 32'h0000_0002);
    query(MODE_PIN, 16'h0002, 1'b1, {24'h00_0000, ERR_EXEC});
    ext_level <= 1'b1;
    query(MODE_PIN, 16'h0001, 1'b0, 32'h0000_0001);
    pins(1'b0, 1'b0);
    wr(OFF_CFG, 32'h0000_0003);
    ext_level <= 1'b0;
    query(MODE_PIN, 16'h0003, 1'b0, 32'h0000_0000);
    pins(1'b1, 1'b1);
    query(MODE_PIN, 16'h0002, 1'b0, 32'h0000_0001);
    pins(1'b1, 1'b0);
    query(MODE_PIN, 16'h0001, 1'b0, 32'h0000_0000);
    pins(1'b0, 1'b0);
    query(MODE_PIN, 16'h0004, 1'b1, {24'h00_0000, ERR_PARSE});
    wr(OFF_CFG, 32'h0000_0001);
    ext_level <= 1'b1;
    query(MODE_PIN, 16'h0000, 1'b0, 32'h0000_0001);
    note("pin access");
    wr(8'h10, 32'h0000_0000, 4'hF, AXI_SLVERR);
    rd(8'h10, 32'h0000_0000, AXI_SLVERR);
    wr(OFF_CMD, 32'h0000_0002, 4'h3, AXI_SLVERR);
    rd(OFF_STATUS, 32'h0000_0002);
    // Refused command leaves the last accepted one in place
    rd(OFF_CMD, {8'h00, 16'h0000, MODE_PIN});
    wr(OFF_CFG, 32'h0000_0002, 4'hE);
    rd(OFF_CFG, 32'h0000_0001);
    wr(OFF_RESP, 32'hFFFF_FFFF);
    rd(OFF_RESP, 32'h0000_0001);
    note("bus refusals");
    repeat (2) @(posedge clk_sys);
    end_of_test();
  end
endmodule // info_query_bench
`default_nettype wire
